/* hdl/tbd_flasher.v */
/*
  Link activity indicator driver: dark, steady or flashing.
  Assumes a one-cycle tick from the main block's divider.
*/
`timescale 1ns/1ps
module tbd_flasher
(
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // control
  input  wire        i_tick,
  input  wire        i_linked,
  input  wire        i_traffic,
  // indicator
  output reg         o_led
);

  reg                phase_reg;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      phase_reg <= 1'b0;
      o_led     <= 1'b0;
    end
    else
    begin
      if (i_tick)
        phase_reg <= ~phase_reg;
      if (!i_linked)
        o_led <= 1'b0;
      else if (i_traffic)
        o_led <= phase_reg;
      else
        o_led <= 1'b1;
    end
  end

endmodule // tbd_flasher

/* hdl/tbd_status.v */
/*
  Terminal bus diagnostic status word and link activity indicator.
  Assumes all inputs synchronous to I_CORE_CLK; events are one-cycle
  pulses from the terminal bus engine, levels are held by it.
*/
// Notes on behaviour
// - a zero word means the bus runs in step with the task, fault free.
// - nonzero means a fault or just a bus cycle longer than the task.
// - bit 0 flags a bus error, cleared by the bus device reset call.
// - bit 1 flags a terminal set that differs from the one at start-up.
// - bit 2 flags configured and actual image lengths that disagree.
// - bit 8 stays set until the first valid input data arrives.
// - bit 9 stays set while an input update has not completed.
// - bit 10 stays set while an output update has not completed.
// - bit 11 flags an expired bus watchdog.
// - bit 15 is set while an acyclic function such as a bus reset runs.
// - one bus update normally completes within about one to five ms.
// - packet-bus mode checks the terminals and, once linked, lights the indicator.
// - the indicator is dark with no packet bus and steady when idle.
// - the indicator flashes while data frames pass.
`timescale 1ns/1ps
`include "tbd_defs.vh"
module tbd_status
#(
  parameter UPDATE_CYCLES = `TBD_UPDATE_CYCLES,
  parameter FLASH_CYCLES  = `TBD_FLASH_CYCLES
)
(
  // clock and reset
  input  wire        I_CORE_CLK,
  input  wire        I_RST_N,
  // bus engine events and levels
  input  wire        I_CYCLE_DONE,
  input  wire        I_BUS_ERR,
  input  wire        I_CFG_MISMATCH,
  input  wire        I_LEN_MISMATCH,
  input  wire        I_INPUT_VALID,
  input  wire        I_IN_UPDATE_START,
  input  wire        I_IN_UPDATE_DONE,
  input  wire        I_OUT_UPDATE_START,
  input  wire        I_OUT_UPDATE_DONE,
  input  wire        I_WDOG_EXPIRED,
  input  wire        I_ACYC_ACTIVE,
  // software
  input  wire        I_BUS_DEVICE_RESET_CALL,
  input  wire        I_RD_STB,
  input  wire [3:0]  I_RD_ADDR,
  output reg  [15:0] O_RD_DATA,
  // packet bus
  input  wire        I_PKT_MODE,
  input  wire        I_PKT_LINKED,
  input  wire        I_PKT_FRAME,
  output wire        O_LINK_ACT_LED,
  output wire        O_CHECK_TERMINALS
);

  // --------------------------------------------------------------------
  // live condition flags
  // --------------------------------------------------------------------
  reg                bus_err_reg;
  reg                no_input_reg;
  reg                in_busy_reg;
  reg                out_busy_reg;
  reg                wdog_reg;
  reg  [15:0]        status_reg;
  reg  [31:0]        upd_cnt_reg;
  reg  [31:0]        flash_cnt_reg;
  reg  [31:0]        traffic_cnt_reg;
  reg                flash_tick_reg;
  wire [15:0]        status_next;
  wire               upd_busy;

  assign upd_busy = in_busy_reg | out_busy_reg;

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      bus_err_reg  <= 1'b0;
      no_input_reg <= 1'b1;
      in_busy_reg  <= 1'b0;
      out_busy_reg <= 1'b0;
      wdog_reg     <= 1'b0;
    end
    else
    begin
      // set wins over the reset call so no error is lost
      if (I_BUS_ERR)
        bus_err_reg <= 1'b1;
      else if (I_BUS_DEVICE_RESET_CALL)
        bus_err_reg <= 1'b0;
      if (I_INPUT_VALID)
        no_input_reg <= 1'b0;
      if (I_IN_UPDATE_START)
        in_busy_reg <= 1'b1;
      else if (I_IN_UPDATE_DONE)
        in_busy_reg <= 1'b0;
      if (I_OUT_UPDATE_START)
        out_busy_reg <= 1'b1;
      else if (I_OUT_UPDATE_DONE)
        out_busy_reg <= 1'b0;
      // internal watchdog: an update overrunning its budget also trips it
      if (I_WDOG_EXPIRED || (upd_busy && upd_cnt_reg >= UPDATE_CYCLES))
        wdog_reg <= 1'b1;
      else if (I_BUS_DEVICE_RESET_CALL)
        wdog_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // update budget counter
  // --------------------------------------------------------------------
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N || !upd_busy)
      upd_cnt_reg <= 32'h00000000;
    else if (upd_cnt_reg < UPDATE_CYCLES)
      upd_cnt_reg <= upd_cnt_reg + 32'h00000001;
  end

  // --------------------------------------------------------------------
  // status word, refreshed at cycle end and every clock while an update or acyclic function runs
  // --------------------------------------------------------------------
  // busy bits show live state, so a long bus cycle yields a nonzero word
  assign status_next = {I_ACYC_ACTIVE, 3'h0,
                        wdog_reg, out_busy_reg,
                        in_busy_reg, no_input_reg,
                        5'h00, I_LEN_MISMATCH,
                        I_CFG_MISMATCH, bus_err_reg};

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
      status_reg <= `TBD_STATUS_RESET;
    else if (I_CYCLE_DONE || I_ACYC_ACTIVE || upd_busy)
      status_reg <= status_next;
  end

  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
      O_RD_DATA <= 16'h0000;
    else if (I_RD_STB)
      O_RD_DATA <= (I_RD_ADDR == `TBD_STATUS_OFFSET) ? status_reg : 16'h0000;
  end

  // --------------------------------------------------------------------
  // link activity indicator
  // --------------------------------------------------------------------
  // traffic is stretched by two flash periods so single frames show
  always @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      flash_cnt_reg   <= 32'h00000000;
      flash_tick_reg  <= 1'b0;
      traffic_cnt_reg <= 32'h00000000;
    end
    else
    begin
      flash_tick_reg <= (flash_cnt_reg == FLASH_CYCLES - 1);
      if (flash_cnt_reg == FLASH_CYCLES - 1)
        flash_cnt_reg <= 32'h00000000;
      else
        flash_cnt_reg <= flash_cnt_reg + 32'h00000001;
      if (I_PKT_FRAME)
        traffic_cnt_reg <= 2 * FLASH_CYCLES;
      else if (traffic_cnt_reg != 32'h00000000)
        traffic_cnt_reg <= traffic_cnt_reg - 32'h00000001;
    end
  end

  assign O_CHECK_TERMINALS = I_PKT_MODE;

  tbd_flasher u_flasher
  (
    .i_clk     (I_CORE_CLK),
    .i_rst_n   (I_RST_N),
    .i_tick    (flash_tick_reg),
    .i_linked  (I_PKT_MODE & I_PKT_LINKED),
    .i_traffic (traffic_cnt_reg != 32'h00000000),
    .o_led     (O_LINK_ACT_LED)
  );

endmodule // tbd_status

/* inc/tbd_defs.vh */
/*
  Constants of the terminal bus diagnostic status block: status word
  layout, bus timing counts and link indicator flash timing.
  Assumes a 250 MHz core clock.
*/
`ifndef TBD_DEFS_VH
`define TBD_DEFS_VH

// ----------------------------------------------------------------------
// status word
// ----------------------------------------------------------------------
`define TBD_STATUS_OFFSET   4'h0
`define TBD_STATUS_WIDTH    16
`define TBD_STATUS_RESET    16'h0100
`define TBD_BIT_BUS_ERR     0
`define TBD_BIT_CFG_CHG     1
`define TBD_BIT_LEN_ERR     2
`define TBD_BIT_NO_INPUT    8
`define TBD_BIT_IN_BUSY     9
`define TBD_BIT_OUT_BUSY    10
`define TBD_BIT_WDOG        11
`define TBD_BIT_ACYC        15

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TBD_CLK_MHZ         250
`define TBD_UPDATE_MAX_MS   5
`define TBD_UPDATE_CYCLES   (`TBD_UPDATE_MAX_MS * 1000 * `TBD_CLK_MHZ)
`define TBD_FLASH_MS        50
`define TBD_FLASH_CYCLES    (`TBD_FLASH_MS * 1000 * `TBD_CLK_MHZ)

`endif

/* sim/tbd_engine_model.sv */
/* terminal chain model: ends a bus cycle every eight clocks and
   sends a frame every other clock while traffic is asked for.
   assumes the core clock and its active low sync reset */
`timescale 1ns/1ps
module tbd_engine_model
(
  // clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // control
  input  wire i_traffic,
  // events
  output reg  o_cycle_done,
  output reg  o_frame
);
  reg [2:0] cnt_reg;
  always @(posedge i_clk)
  begin
    cnt_reg      <= i_rst_n ? cnt_reg + 3'h1 : 3'h0;
    o_cycle_done <= i_rst_n && cnt_reg == 3'h7;
    o_frame      <= i_rst_n && i_traffic && cnt_reg[0];
  end
endmodule // tbd_engine_model

/* sim/tbd_status_sva.sv */
/* port checker for the status read path and link indicator.
   assumes it is bound into tbd_status, one clock, sync reset */
`timescale 1ns/1ps
module tbd_status_sva
#(
  parameter UPDATE_CYCLES = 20,
  parameter FLASH_CYCLES  = 4
)
(
  // clock and reset
  input wire        I_CORE_CLK,
  input wire        I_RST_N,
  // read port
  input wire        I_RD_STB,
  input wire [3:0]  I_RD_ADDR,
  input wire [15:0] O_RD_DATA,
  // packet bus
  input wire        I_PKT_MODE,
  input wire        I_PKT_LINKED,
  input wire        I_PKT_FRAME,
  input wire        O_LINK_ACT_LED,
  input wire        O_CHECK_TERMINALS
);
  // slack of a few clocks covers the one-cycle indicator lag
  localparam int QUIET = 2 * FLASH_CYCLES + 3;
  localparam int LIM   = 2 * FLASH_CYCLES + 2;
  wire      lnk = I_PKT_MODE && I_PKT_LINKED;
  reg [7:0] quiet_reg;
  always @(posedge I_CORE_CLK)
    quiet_reg <= (!I_RST_N || !lnk || I_PKT_FRAME) ? 8'h00 :
                 (quiet_reg == 8'hFF ? quiet_reg : quiet_reg + 8'h01);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  refused_read_a: assert property (I_RD_STB && I_RD_ADDR != 4'h0
    |=> O_RD_DATA == 16'h0000) else $error("unmapped read not zero");
  reserved_zero_a: assert property (
    (O_RD_DATA & 16'h70F8) == 16'h0000)
    else $error("unlisted status bit set");
  read_hold_a: assert property (!I_RD_STB |=> $stable(O_RD_DATA))
    else $error("read data moved without strobe");
  read_cause_a: assert property (
    $changed(O_RD_DATA) |-> $past(I_RD_STB))
    else $error("read data changed late");
  reset_out_a: assert property ($rose(I_RST_N)
    |-> O_RD_DATA == 16'h0000 && !O_LINK_ACT_LED) else $error("reset out");
  check_term_a: assert property (O_CHECK_TERMINALS == I_PKT_MODE)
    else $error("terminal check not following mode");
  led_dark_a: assert property (!lnk |=> !O_LINK_ACT_LED)
    else $error("indicator lit without link");
  led_steady_a: assert property (
    quiet_reg >= QUIET |-> O_LINK_ACT_LED)
    else $error("indicator not steady when idle");
  led_flash_a: assert property (lnk && I_PKT_FRAME |-> ##[1:LIM]
    ($changed(O_LINK_ACT_LED) || !lnk)) else $error("indicator not flashing");
  cover property (lnk && O_LINK_ACT_LED);
  cover property (lnk && I_PKT_FRAME ##1 $changed(O_LINK_ACT_LED));
  cover property (I_RD_STB && I_RD_ADDR != 4'h0);
  cover property (quiet_reg >= QUIET && O_LINK_ACT_LED);
endmodule // tbd_status_sva
bind tbd_status tbd_status_sva #(.UPDATE_CYCLES(UPDATE_CYCLES),
  .FLASH_CYCLES(FLASH_CYCLES)) u_sva (.I_CORE_CLK(I_CORE_CLK),
  .I_RST_N(I_RST_N), .I_RD_STB(I_RD_STB), .I_RD_ADDR(I_RD_ADDR),
  .O_RD_DATA(O_RD_DATA), .I_PKT_MODE(I_PKT_MODE),
  .I_PKT_LINKED(I_PKT_LINKED), .I_PKT_FRAME(I_PKT_FRAME),
  .O_LINK_ACT_LED(O_LINK_ACT_LED), .O_CHECK_TERMINALS(O_CHECK_TERMINALS));

/* sim/tbd_status_tb.sv */
/* bench for the status word and link indicator.
   assumes the engine model supplies cycle ends and frames */
`timescale 1ns/1ps
module tbd_status_tb;
  reg         clk;
  reg         rst_n;
  reg  [13:0] ev;
  reg         stb;
  reg  [3:0]  adr;
  reg         p;
  wire [15:0] rd;
  wire        led;
  wire        chkt;
  wire        cyc;
  wire        frm;
  integer     error_cnt;
  integer     check_count;
  integer     i;
  integer     n;
  tbd_engine_model u_eng (.i_clk(clk), .i_rst_n(rst_n),
    .i_traffic(ev[13]), .o_cycle_done(cyc), .o_frame(frm));
  tbd_status #(.UPDATE_CYCLES(20), .FLASH_CYCLES(4)) uut (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CYCLE_DONE(cyc),
    .I_BUS_ERR(ev[0]), .I_CFG_MISMATCH(ev[1]), .I_LEN_MISMATCH(ev[2]),
    .I_INPUT_VALID(ev[3]), .I_IN_UPDATE_START(ev[4]),
    .I_IN_UPDATE_DONE(ev[5]), .I_OUT_UPDATE_START(ev[6]),
    .I_OUT_UPDATE_DONE(ev[7]), .I_WDOG_EXPIRED(ev[8]),
    .I_ACYC_ACTIVE(ev[9]), .I_BUS_DEVICE_RESET_CALL(ev[10]),
    .I_RD_STB(stb), .I_RD_ADDR(adr), .O_RD_DATA(rd),
    .I_PKT_MODE(ev[11]), .I_PKT_LINKED(ev[12]), .I_PKT_FRAME(frm),
    .O_LINK_ACT_LED(led), .O_CHECK_TERMINALS(chkt));
  // ----
  // tasks
  // ----
  task print_verdict;
  begin
    $display("mismatches %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task pl(input integer k);
  begin
    @(posedge clk) ev[k] <= 1'h1;
    @(posedge clk) ev[k] <= 1'h0;
  end
  endtask
  // a poll every dozen clocks leaves room for one whole bus cycle
  task rw(input [3:0] a, input [15:0] e);
  begin
    repeat (12) @(posedge clk);
    stb <= 1'h1;
    adr <= a;
    @(posedge clk) stb <= 1'h0;
    #1 chk("status", rd, e);
  end
  endtask
  task wled(input v);
  begin
    n = 0;
    while (led !== v && n < 40)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if (led !== v)
    begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'h0;
    ev = 14'h0;
    stb = 1'h0;
    adr = 4'h0;
    error_cnt = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    rw(4'h0, 16'h0100);
    rw(4'h5, 16'h0000);
    pl(3);
    rw(4'h0, 16'h0000);
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge clk) ev[i == 2 ? 9 : i + 1] <= 1'h1;
      rw(4'h0, i == 2 ? 16'h8000 : 16'h0002 << i);
      @(posedge clk) ev[i == 2 ? 9 : i + 1] <= 1'h0;
      rw(4'h0, 16'h0000);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      pl(i * 8);
      rw(4'h0, i ? 16'h0800 : 16'h0001);
      pl(10);
      rw(4'h0, 16'h0000);
    end
    // error and reset call in one cycle: the error must survive
    @(posedge clk) {ev[10], ev[0]} <= 2'h3;
    @(posedge clk) {ev[10], ev[0]} <= 2'h0;
    rw(4'h0, 16'h0001);
    pl(10);
    rw(4'h0, 16'h0000);
    pl(4);
    rw(4'h0, 16'h0200);
    rw(4'h0, 16'h0A00);
    pl(5);
    pl(10);
    rw(4'h0, 16'h0000);
    pl(6);
    rw(4'h0, 16'h0400);
    pl(7);
    rw(4'h0, 16'h0000);
    @(posedge clk) ev[11] <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chk("check", {15'h0, chkt}, 16'h0001);
    chk("unlinked", {15'h0, led}, 16'h0000);
    @(posedge clk) ev[12] <= 1'h1;
    wled(1'h1);
    repeat (16) @(posedge clk);
    #1 chk("steady", {15'h0, led}, 16'h0001);
    @(posedge clk) ev[13] <= 1'h1;
    n = 0;
    p = led;
    repeat (40)
    begin
      @(negedge clk);
      n = n + (led !== p);
      p = led;
    end
    chk("flash", {15'h0, n >= 4}, 16'h0001);
    @(posedge clk) ev[13] <= 1'h0;
    repeat (16) @(posedge clk);
    #1 chk("idle", {15'h0, led}, 16'h0001);
    @(posedge clk) ev[12:11] <= 2'h0;
    wled(1'h0);
    #1 chk("dark", {14'h0, chkt, led}, 16'h0000);
    // a reset in mid-run must bring back the no-input flag
    @(posedge clk) rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rw(4'h0, 16'h0100);
    print_verdict;
  end
endmodule // tbd_status_tb
